// >>> verilog/cmc_defs.vh
// constants for the common mode control register block
`ifndef CMC_DEFS_VH
`define CMC_DEFS_VH
// register offsets (16-bit common block offsets)
`define CMC_MODE_CONTROL_ADDR 16'h0000
`define CMC_INT_STATUS_ADDR 16'h0015
`define CMC_INT_MASK_ADDR 16'h0016
// mode control field positions
`define CMC_SOFT_RESET_BIT 7
`define CMC_WAKE_ON_LAN_BIT 5
`define CMC_PING_BLOCK_BIT 4
`define CMC_PPPOE_BIT 3
`define CMC_FORCE_ARP_BIT 1
// writable bits of mode control; reserved 6, 2, 0 stay zero
`define CMC_MODE_WMASK 8'hBA
// magic packet flag position in status and mask
`define CMC_MAGIC_FLAG_BIT 4
// writable bits of status and mask (upper nibble)
`define CMC_INT_WMASK 8'hF0
// reset values
`define CMC_MODE_RESET 8'h00
`define CMC_INT_RESET 8'h00
// magic packet sync stream: six bytes of all ones
`define CMC_SYNC_BYTE 8'hFF
`define CMC_SYNC_LEN 3'd6
// software reset pulse length in cycles
`define CMC_SWRST_CYCLES 4'd8
`endif

// >>> verilog/cmc_sync_detect.v
// magic packet sync stream detector for the wake-on-lan path
`timescale 1ns/100ps
`include "cmc_defs.vh"
module cmc_sync_detect (
    input wire clk,
    input wire rst_b,
    input wire clearIn,
    input wire payloadStart,
    input wire byteValid,
    input wire [7:0] byteData,
    output reg syncSeen_ff
);
    reg [2:0] count_ff; // leading 0xff bytes seen so far
    reg active_ff; // still inside the leading run
    // counts only the run at the very start of the payload
    always @(posedge clk) begin
        if (!rst_b || clearIn) begin
            count_ff <= 3'd0;
            active_ff <= 1'b0;
            syncSeen_ff <= 1'b0;
        end else if (payloadStart) begin
            // a new payload restarts the search
            count_ff <= 3'd0;
            active_ff <= 1'b1;
            syncSeen_ff <= 1'b0;
        end else if (byteValid && active_ff) begin
            if (byteData == `CMC_SYNC_BYTE) begin
                count_ff <= count_ff + 3'd1;
                if (count_ff + 3'd1 == `CMC_SYNC_LEN) begin
                    syncSeen_ff <= 1'b1; // [RULE_05]
                    active_ff <= 1'b0;
                end
            end else begin
                // any other byte first means no magic packet
                active_ff <= 1'b0;
            end
        end
    end
endmodule

// >>> verilog/cmc_mode_control.v
// common mode control register with wake-on-lan interrupt path
// What this block does
// RULE_01 - writing bit 7 resets all internal registers
// RULE_02 - soft reset bit clears itself afterwards
// RULE_03 - wake-on-lan magic packet drives interrupt low
// RULE_04 - host opens a udp socket first
// RULE_05 - magic packet starts with six 0xff bytes
// RULE_06 - bit 4 suppresses ping replies
// RULE_07 - bit 3 enables pppoe mode
// RULE_08 - adsl hosts set pppoe bit
// RULE_09 - bit 1 enables force-arp mode
// RULE_10 - force-arp sends arp request per send
// RULE_11 - mode register 8-bit at 0x0000, resets 0x00
// RULE_12 - magic packet sets status bit 4
// RULE_13 - interrupt pin gated by mask bit
// RULE_14 - reserved bits read zero, ignore writes
// RULE_15 - host polls soft reset until zero
`timescale 1ns/100ps
`include "cmc_defs.vh"
module cmc_mode_control (
    input wire clk,
    input wire rst_b,
    // register access from the host interface, core clock domain
    input wire regWrite,
    input wire regRead,
    input wire [15:0] regAddr,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata_ff,
    output reg regRvalid_ff,
    // udp receive stream from the protocol engine
    input wire udpPayloadStart,
    input wire udpByteValid,
    input wire [7:0] udpByteData,
    input wire udpPacketDone,
    // engine requests
    input wire pingRequest,
    input wire dataSendRequest,
    // outputs to the engine and the pin
    output reg softResetOut_ff,
    output reg pingReplyEnable_ff,
    output reg pppoeEnable_ff,
    output reg forceArpEnable_ff,
    output reg pingReplyGo_ff,
    output reg arpRequestGo_ff,
    output reg interrupt_out_n_ff
);
    reg [7:0] modeControl_ff; // stored mode register
    reg [7:0] intStatus_ff; // sticky interrupt flags
    reg [7:0] intMask_ff; // interrupt enables
    reg [3:0] swrstCnt_ff; // soft reset duration counter
    reg swrstActive_ff; // soft reset in progress
    wire syncSeen; // payload opened with the sync stream
    wire localClear; // hard or soft reset condition
    wire magicEvent; // validated magic packet this cycle
    wire wrMode;
    wire wrStatus;
    wire wrMask;
    wire rdMode; // address hit on the mode register, not qualified by regRead
    wire rdStatus; // address hit on the status register, not qualified by regRead
    wire rdMask; // address hit on the mask register, not qualified by regRead

    // timing summary for users of this block:
    // - a read strobe is answered one cycle later on regRdata_ff,
    //   together with a one-cycle regRvalid_ff pulse
    // - a write to the mode offset with bit 7 set starts a soft
    //   reset of a fixed number of cycles; writes are ignored while
    //   it runs, so the host must poll bit 7 before anything else
    // - mode outputs follow the register one cycle after a write,
    //   and the engine strobes follow those outputs, so a strobe
    //   carries the enable level of the cycle before it, which may differ from the one the engine sees
    // - the interrupt pin follows the status and mask registers
    //   one cycle late; there is no assert-wait timer, so a new
    //   flag shows on the pin right after an old one is cleared
    // limitation: only the magic packet flag lives here, the other
    // status bits read zero and the mask keeps its whole upper nibble

    // true when the bus offset selects one register of this block;
    // shared by the write and read decodes so both agree on the map
    function offsetHit;
        input [15:0] addr;
        input [15:0] offset;
        begin
            offsetHit = (addr == offset);
        end
    endfunction

    // value the host sees at the mode offset: bit 7 is not stored,
    // it shows the running soft reset instead, which is what lets
    // the host poll for the end of the reset
    function [7:0] modeReadback;
        input [7:0] stored;
        input running;
        begin
            modeReadback = (stored & `CMC_MODE_WMASK) | {running, 7'h00};
        end
    endfunction

    // merged reset: soft reset clears the mode, status and mask registers
    assign localClear = !rst_b || swrstActive_ff; // [RULE_01]
    assign wrMode = regWrite && offsetHit(regAddr, `CMC_MODE_CONTROL_ADDR); // [RULE_11]
    assign wrStatus = regWrite && offsetHit(regAddr, `CMC_INT_STATUS_ADDR);
    assign wrMask = regWrite && offsetHit(regAddr, `CMC_INT_MASK_ADDR);
    assign rdMode = offsetHit(regAddr, `CMC_MODE_CONTROL_ADDR); // [RULE_11]
    assign rdStatus = offsetHit(regAddr, `CMC_INT_STATUS_ADDR);
    assign rdMask = offsetHit(regAddr, `CMC_INT_MASK_ADDR);

    // only a packet that finished normally with the sync stream counts
    assign magicEvent = udpPacketDone && syncSeen
        && modeControl_ff[`CMC_WAKE_ON_LAN_BIT]; // [RULE_03] [RULE_05]

    cmc_sync_detect uSync (
        .clk(clk),
        .rst_b(rst_b),
        .clearIn(swrstActive_ff),
        .payloadStart(udpPayloadStart),
        .byteValid(udpByteValid),
        .byteData(udpByteData),
        .syncSeen_ff(syncSeen)
    );

    // soft reset sequencer: a fixed-length internal reset then self-clear
    always @(posedge clk) begin
        if (!rst_b) begin
            swrstActive_ff <= 1'b0;
            swrstCnt_ff <= 4'd0;
        end else if (swrstActive_ff) begin
            if (swrstCnt_ff == `CMC_SWRST_CYCLES - 4'd1) begin
                swrstActive_ff <= 1'b0; // [RULE_02]
                swrstCnt_ff <= 4'd0;
            end else begin
                swrstCnt_ff <= swrstCnt_ff + 4'd1;
            end
        end else if (wrMode && regWdata[`CMC_SOFT_RESET_BIT]) begin
            swrstActive_ff <= 1'b1; // [RULE_01]
        end
    end

    // mode control register; bit 7 mirrors the running soft reset
    always @(posedge clk) begin
        if (localClear) begin
            modeControl_ff <= `CMC_MODE_RESET; // [RULE_11]
        end else if (wrMode) begin
            // reserved bits masked off, soft reset bit not stored here
            modeControl_ff <= regWdata & `CMC_MODE_WMASK
                & ~(8'h01 << `CMC_SOFT_RESET_BIT); // [RULE_14]
        end
    end

    // interrupt status: write one to clear, a new event wins the clear
    always @(posedge clk) begin
        if (localClear) begin
            intStatus_ff <= `CMC_INT_RESET;
        end else begin
            intStatus_ff[`CMC_MAGIC_FLAG_BIT] <= magicEvent
                || (intStatus_ff[`CMC_MAGIC_FLAG_BIT]
                && !(wrStatus && regWdata[`CMC_MAGIC_FLAG_BIT])); // [RULE_12]
        end
    end

    // interrupt mask register; only the upper nibble exists
    always @(posedge clk) begin
        if (localClear) begin
            intMask_ff <= `CMC_INT_RESET;
        end else if (wrMask) begin
            intMask_ff <= regWdata & `CMC_INT_WMASK;
        end
    end

    // read path: one cycle latency, unmapped offsets read zero
    always @(posedge clk) begin
        if (!rst_b) begin
            regRdata_ff <= 8'h00;
            regRvalid_ff <= 1'b0;
        end else begin
            regRvalid_ff <= regRead;
            if (regRead) begin
                if (rdMode) begin
                    // reserved bits masked once more on the way out
                    regRdata_ff <= modeReadback(modeControl_ff,
                        swrstActive_ff); // [RULE_02] [RULE_14]
                end else if (rdStatus) begin
                    regRdata_ff <= intStatus_ff & `CMC_INT_WMASK;
                end else if (rdMask) begin
                    regRdata_ff <= intMask_ff & `CMC_INT_WMASK;
                end else begin
                    // unmapped offsets read zero
                    regRdata_ff <= 8'h00;
                end
            end
        end
    end

    // mode outputs and engine strobes, all registered
    always @(posedge clk) begin
        if (!rst_b) begin
            softResetOut_ff <= 1'b0;
            pingReplyEnable_ff <= 1'b1;
            pppoeEnable_ff <= 1'b0;
            forceArpEnable_ff <= 1'b0;
            pingReplyGo_ff <= 1'b0;
            arpRequestGo_ff <= 1'b0;
            interrupt_out_n_ff <= 1'b1;
        end else begin
            // other engine blocks reset while this is high
            softResetOut_ff <= swrstActive_ff; // [RULE_01]
            pingReplyEnable_ff <= !modeControl_ff[`CMC_PING_BLOCK_BIT]; // [RULE_06]
            pppoeEnable_ff <= modeControl_ff[`CMC_PPPOE_BIT]; // [RULE_07]
            forceArpEnable_ff <= modeControl_ff[`CMC_FORCE_ARP_BIT]; // [RULE_09]
            // a ping is answered only while blocking is off; gated by the
            // visible enable, so the strobe follows that output of the cycle before
            pingReplyGo_ff <= pingRequest && !swrstActive_ff
                && pingReplyEnable_ff; // [RULE_06]
            // every send outside a soft reset triggers an arp request in force-arp mode
            arpRequestGo_ff <= dataSendRequest && !swrstActive_ff
                && forceArpEnable_ff; // [RULE_10]
            // pin low while any unmasked flag stands
            interrupt_out_n_ff <= !(|(intStatus_ff & intMask_ff)); // [RULE_03] [RULE_13]
        end
    end
endmodule

// >>> verification/cmc_mode_control_chk.sv
// assertion checker for the mode control block
`timescale 1ns/100ps
module cmc_mode_control_chk (
    input wire clk,
    input wire rst_b,
    input wire regRead,
    input wire [15:0] regAddr,
    input wire [7:0] regRdata_ff,
    input wire regRvalid_ff,
    input wire pingRequest,
    input wire pingReplyEnable_ff,
    input wire pingReplyGo_ff,
    input wire dataSendRequest,
    input wire forceArpEnable_ff,
    input wire arpRequestGo_ff,
    input wire softResetOut_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_rv; regRead |=> regRvalid_ff; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_idle; !regRead |=> !regRvalid_ff; endproperty
    a_idle: assert property (p_idle) else $error("stray read answer");
    property p_rsv; regRead && regAddr == 16'h0000 |=> (regRdata_ff & 8'h45) == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_unm; regRead && regAddr == 16'h0040 |=> regRdata_ff == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read nonzero");
    property p_arp; dataSendRequest && forceArpEnable_ff |=> arpRequestGo_ff || softResetOut_ff; endproperty
    a_arp: assert property (p_arp) else $error("arp request missing");
    property p_arpc; arpRequestGo_ff |-> $past(dataSendRequest); endproperty
    a_arpc: assert property (p_arpc) else $error("arp request uncaused");
    property p_pb; pingRequest && !pingReplyEnable_ff |=> !pingReplyGo_ff; endproperty
    a_pb: assert property (p_pb) else $error("blocked ping answered");
    property p_srst; $rose(softResetOut_ff) |-> softResetOut_ff [*8] ##1 !softResetOut_ff; endproperty
    a_srst: assert property (p_srst) else $error("soft reset length");
endmodule
bind cmc_mode_control cmc_mode_control_chk u_chk (.*);

// >>> verification/cmc_host_model.sv
// host model driving the register port of the mode control block
`timescale 1ns/100ps
module cmc_host_model (
    input wire clk,
    output reg regWrite,
    output reg regRead,
    output reg [15:0] regAddr,
    output reg [7:0] regWdata,
    input wire [7:0] regRdata_ff
);
    initial begin regWrite = 1'h0; regRead = 1'h0; regAddr = 16'h0000; regWdata = 8'h00; end
    // one-cycle write strobe; data is scrambled once released
    task wr(input [15:0] a, input [7:0] d); begin
        @(negedge clk); regAddr = a; regWdata = d; regWrite = 1'h1;
        @(negedge clk); regWrite = 1'h0; regWdata = ~d; regAddr = ~a; end endtask
    // read answer lands one cycle after the strobe edge
    task rd(input [15:0] a, output [7:0] d); begin
        @(negedge clk); regAddr = a; regRead = 1'h1;
        @(negedge clk); regRead = 1'h0; d = regRdata_ff; regAddr = ~a; end endtask
endmodule

// >>> verification/cmc_mode_control_test.sv
// self-checking bench for the mode control block
`timescale 1ns/100ps
module cmc_mode_control_test;
    reg clk = 1'h0, rst_b = 1'h0, udpPayloadStart = 1'h0, udpByteValid = 1'h0;
    reg udpPacketDone = 1'h0, pingRequest = 1'h0, dataSendRequest = 1'h0;
    reg [7:0] udpByteData = 8'h00, v;
    wire regWrite, regRead, regRvalid_ff, softResetOut_ff, pingReplyEnable_ff, pppoeEnable_ff;
    wire forceArpEnable_ff, pingReplyGo_ff, arpRequestGo_ff, interrupt_out_n_ff;
    wire [15:0] regAddr;
    wire [7:0] regWdata, regRdata_ff;
    integer failCount = 0, compares = 0, i;
    always #4 clk = ~clk;
    cmc_mode_control u_dut (.*);
    cmc_host_model u_host (.*);
    task chk(input [8*10:1] n, input [7:0] s, input [7:0] e); begin
        compares = compares + 1;
        if (s !== e) begin failCount = failCount + 1;
            $display("wrong value %0s expected %h seen %h", n, e, s); end end endtask
    task endSim; begin
        $display("compares %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish; end endtask
    // packet of n sync bytes, then processed-normally pulse
    task pkt(input integer n); begin
        @(negedge clk); udpPayloadStart = 1'h1;
        for (i = 0; i < n; i = i + 1) begin
            @(negedge clk); udpPayloadStart = 1'h0; udpByteValid = 1'h1; udpByteData = 8'hFF; end
        @(negedge clk); udpByteValid = 1'h0; udpByteData = 8'h00; udpPacketDone = 1'h1;
        @(negedge clk); udpPacketDone = 1'h0; @(negedge clk); @(negedge clk); end endtask
    task tReset; begin
        u_host.rd(16'h0000, v); chk("mode", v, 8'h00);
        u_host.rd(16'h0040, v); chk("unmapped", v, 8'h00);
        @(negedge clk); pingRequest = 1'h1;
        @(negedge clk); pingRequest = 1'h0; chk("reply", pingReplyGo_ff, 1'h1);
        $display("reset test done"); end endtask
    task tBits; begin // all writable bits but soft reset; adsl host sets pppoe
        u_host.wr(16'h0000, 8'h7F);
        u_host.rd(16'h0000, v); chk("mode", v, 8'h3A);
        chk("pppoe", pppoeEnable_ff, 1'h1);
        chk("arpMode", forceArpEnable_ff, 1'h1);
        @(negedge clk); pingRequest = 1'h1; dataSendRequest = 1'h1;
        @(negedge clk); pingRequest = 1'h0; dataSendRequest = 1'h0;
        chk("blocked", pingReplyGo_ff, 1'h0);
        chk("arpGo", arpRequestGo_ff, 1'h1);
        $display("bits test done"); end endtask
    task tMagic; begin // udp socket taken as open by the host
        u_host.wr(16'h0016, 8'h10); u_host.wr(16'h0000, 8'h20);
        pkt(5); u_host.rd(16'h0015, v); chk("short", v, 8'h00);
        pkt(6); u_host.rd(16'h0015, v); chk("status", v, 8'h10);
        chk("intPin", interrupt_out_n_ff, 1'h0);
        u_host.wr(16'h0016, 8'h00); @(negedge clk);
        chk("masked", interrupt_out_n_ff, 1'h1);
        u_host.wr(16'h0015, 8'h10); u_host.rd(16'h0015, v); chk("cleared", v, 8'h00);
        $display("magic test done"); end endtask
    task tSrst; begin // polls bounded; a stuck bit ends the run
        u_host.wr(16'h0000, 8'h08); u_host.wr(16'h0016, 8'h10); u_host.wr(16'h0000, 8'h80);
        v = 8'h80;
        for (i = 0; i < 20 && v[7] !== 1'h0; i = i + 1) u_host.rd(16'h0000, v);
        chk("selfClear", v, 8'h00);
        if (v[7] !== 1'h0) endSim;
        u_host.rd(16'h0016, v); chk("mask", v, 8'h00);
        chk("pppoe", pppoeEnable_ff, 1'h0);
        $display("soft reset test done"); end endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'h1;
        tReset; tBits; tMagic; tSrst;
        endSim;
    end
endmodule
